//--- logic/ppps_top.sv
// Palette access port, attribute shift and high-colour stage.
// Assumes all inputs synchronous to REF_CLK; host strobes last one cycle.
`default_nettype none
module ppps_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [15:0] IO_ADDR,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_RDATA_VALID,
    input wire logic ENHANCED_MAP,
    input wire logic NINE_DOT,
    input wire logic [5:0] PAL_COLOR,
    input wire logic [3:0] PIX_NIBBLE,
    output logic [7:0] PIX_ADDR,
    output logic [17:0] LUT_RGB,
    output logic [3:0] PAN_SHIFT,
    output logic [1:0] VIDEO_STATUS
);
    ////////////////////////////////////////////////////////////////////////////
    ppps_pkg::ppps_state_t s; // Registered state
    ppps_pkg::ppps_state_t n; // Next state
    ppps_pkg::ppps_io_req_t req; // Bundled host access
    logic byte_mode; // Two nibbles per pixel
    logic bypass; // High-colour replaces bits 5-4
    logic graphics; // Graphics rather than text
    logic [7:0] sel_idx; // Index the data port works on
    logic [7:0] next_idx; // Auto-incremented index

    assign req = '{addr: IO_ADDR, wr: IO_WR, rd: IO_RD, wdata: IO_WDATA};
    assign byte_mode = s.mode[ppps_pkg::MODE_BYTE_PIX_BIT];
    assign bypass = s.mode[ppps_pkg::MODE_BYPASS_BIT];
    assign graphics = s.mode[ppps_pkg::MODE_GRAPHICS_BIT];
    assign sel_idx = (s.status == ppps_pkg::STATUS_READ) ? s.rd_idx : s.wr_idx;
    assign next_idx = sel_idx + 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for host port and pixel path
    always_comb begin
        n = s;
        n.rvalid = 1'b0;
        // Nibble pairing runs at half rate only in byte mode
        n.phase = byte_mode ? ~s.phase : 1'b0;
        if (byte_mode) begin
            if (!s.phase) begin
                n.nib_hi = PIX_NIBBLE;
            end else begin
                n.color = {s.nib_hi, PIX_NIBBLE};
            end
        end else begin
            // Top bits always from high-colour outside byte mode
            n.color = {s.hicolor[3:2], bypass ? s.hicolor[1:0] : PAL_COLOR[5:4], PAL_COLOR[3:0]};
        end
        n.pix_addr = s.color & s.mask;
        n.rgb = s.lut[s.pix_addr];
        // Effective left shift for the pixel shifter
        if (ENHANCED_MAP) begin
            n.pan = 4'h0;
        end else if (byte_mode) begin
            n.pan = {1'b0, s.shift[3:1]};
        end else if (NINE_DOT && !graphics) begin
            // Codes above 1000 are not meaningful; treated as no shift
            n.pan = (s.shift[3:0] < ppps_pkg::NINE_DOT_ZERO_CODE) ? 4'(s.shift[3:0] + 4'h1) : 4'h0;
        end else begin
            n.pan = {1'b0, s.shift[2:0]};
        end
        // Host writes
        if (req.wr) begin
            case (req.addr)
                ppps_pkg::ADDR_ATTR_WR: begin
                    n.attr_toggle = ~s.attr_toggle;
                    if (!s.attr_toggle) begin
                        n.attr_index = req.wdata[5:0];
                    end else begin
                        case (s.attr_index[4:0])
                            ppps_pkg::IDX_MODE: n.mode = req.wdata & ppps_pkg::MODE_WR_MASK;
                            ppps_pkg::IDX_PLANE: n.plane = req.wdata & ppps_pkg::PLANE_WR_MASK;
                            ppps_pkg::IDX_SHIFT: n.shift = req.wdata & ppps_pkg::LOW_NIBBLE_MASK;
                            ppps_pkg::IDX_HICOLOR: n.hicolor = req.wdata & ppps_pkg::LOW_NIBBLE_MASK;
                            default: ; // Other attribute registers live elsewhere
                        endcase
                    end
                end
                ppps_pkg::ADDR_MASK: n.mask = req.wdata;
                ppps_pkg::ADDR_RD_INDEX: begin
                    // Read sequence starts with the entry preloaded
                    n.rd_idx = req.wdata;
                    n.hold = s.lut[req.wdata];
                    n.comp = ppps_pkg::COMP_RED;
                    n.status = ppps_pkg::STATUS_READ;
                end
                ppps_pkg::ADDR_WR_INDEX: begin
                    n.wr_idx = req.wdata;
                    n.comp = ppps_pkg::COMP_RED;
                    n.status = ppps_pkg::STATUS_WRITE;
                end
                ppps_pkg::ADDR_DATA: begin
                    // Only low six bits of each byte are kept
                    case (s.comp)
                        ppps_pkg::COMP_RED: begin
                            n.red = req.wdata[5:0];
                            n.comp = ppps_pkg::COMP_GREEN;
                        end
                        ppps_pkg::COMP_GREEN: begin
                            n.green = req.wdata[5:0];
                            n.comp = ppps_pkg::COMP_BLUE;
                        end
                        default: begin
                            // Entry written only once the triple is whole
                            n.lut[sel_idx] = {s.red, s.green, req.wdata[5:0]};
                            if (s.status == ppps_pkg::STATUS_READ) begin
                                n.rd_idx = next_idx;
                            end else begin
                                n.wr_idx = next_idx;
                            end
                            n.comp = ppps_pkg::COMP_RED;
                        end
                    endcase
                end
                default: ; // Unmapped: ignored
            endcase
        end
        // Host reads
        if (req.rd) begin
            n.rvalid = 1'b1;
            n.rdata = ppps_pkg::RESET_BYTE;
            case (req.addr)
                ppps_pkg::ADDR_ATTR_WR: n.rdata = {2'b00, s.attr_index};
                ppps_pkg::ADDR_ATTR_RD: begin
                    case (s.attr_index[4:0])
                        ppps_pkg::IDX_MODE: n.rdata = s.mode;
                        ppps_pkg::IDX_PLANE: n.rdata = s.plane;
                        ppps_pkg::IDX_SHIFT: n.rdata = s.shift;
                        ppps_pkg::IDX_HICOLOR: n.rdata = s.hicolor;
                        default: n.rdata = ppps_pkg::RESET_BYTE;
                    endcase
                end
                ppps_pkg::ADDR_STAT_MONO, ppps_pkg::ADDR_STAT_COLOR: n.attr_toggle = 1'b0;
                ppps_pkg::ADDR_MASK: n.rdata = s.mask;
                ppps_pkg::ADDR_RD_INDEX: n.rdata = {6'h00, s.status};
                ppps_pkg::ADDR_WR_INDEX: n.rdata = s.wr_idx;
                ppps_pkg::ADDR_DATA: begin
                    case (s.comp)
                        ppps_pkg::COMP_RED: begin
                            n.rdata = {2'b00, s.hold[17:12]};
                            n.comp = ppps_pkg::COMP_GREEN;
                        end
                        ppps_pkg::COMP_GREEN: begin
                            n.rdata = {2'b00, s.hold[11:6]};
                            n.comp = ppps_pkg::COMP_BLUE;
                        end
                        default: begin
                            n.rdata = {2'b00, s.hold[5:0]};
                            n.hold = s.lut[next_idx];
                            if (s.status == ppps_pkg::STATUS_READ) begin
                                n.rd_idx = next_idx;
                            end else begin
                                n.wr_idx = next_idx;
                            end
                            n.comp = ppps_pkg::COMP_RED;
                        end
                    endcase
                end
                default: n.rdata = ppps_pkg::RESET_BYTE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; table cleared at reset for determinism
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            s <= '0;
            s.mask <= ppps_pkg::RESET_MASK;
            s.comp <= ppps_pkg::COMP_RED;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign IO_RDATA = s.rdata;
    assign IO_RDATA_VALID = s.rvalid;
    assign PIX_ADDR = s.pix_addr;
    assign LUT_RGB = s.rgb;
    assign PAN_SHIFT = s.pan;
    // Test select picks a pair of colour bits for status
    always_comb begin
        case (s.plane[ppps_pkg::PLANE_VTS_LSB +: 2])
            2'h0: VIDEO_STATUS = {s.color[2], s.color[0]};
            2'h1: VIDEO_STATUS = {s.color[5], s.color[4]};
            2'h2: VIDEO_STATUS = {s.color[3], s.color[1]};
            default: VIDEO_STATUS = {s.color[7], s.color[6]};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    logic wr_data; // Host data-port write
    logic rd_data; // Host data-port read
    assign wr_data = IO_WR && IO_ADDR == ppps_pkg::ADDR_DATA;
    assign rd_data = IO_RD && IO_ADDR == ppps_pkg::ADDR_DATA;

    property p_vts;
        s.plane[5:4] == 2'h3 |-> VIDEO_STATUS == s.color[7:6];
    endproperty
    a_vts: assert property (p_vts) else $error("status pair wrong");

    property p_enh;
        ENHANCED_MAP |=> PAN_SHIFT == 4'h0;
    endproperty
    a_enh: assert property (p_enh) else $error("pan not suppressed");

    property p_nine;
        !ENHANCED_MAP && NINE_DOT && !graphics && !byte_mode && s.shift[3] == 1'b0 |=>
            PAN_SHIFT == $past(s.shift[3:0]) + 4'h1;
    endproperty
    a_nine: assert property (p_nine) else $error("nine-dot shift wrong");

    property p_byte_pan;
        !ENHANCED_MAP && byte_mode |=> PAN_SHIFT == {1'b0, $past(s.shift[3:1])};
    endproperty
    a_byte_pan: assert property (p_byte_pan) else $error("byte-mode shift wrong");

    property p_mask;
        ##1 PIX_ADDR == ($past(s.color) & $past(s.mask));
    endproperty
    a_mask: assert property (p_mask) else $error("mask not applied");

    property p_rd_start;
        IO_WR && IO_ADDR == ppps_pkg::ADDR_RD_INDEX |=>
            s.status == ppps_pkg::STATUS_READ && s.hold == s.lut[$past(IO_WDATA)];
    endproperty
    a_rd_start: assert property (p_rd_start) else $error("read sequence not started");

    property p_rd_byte;
        rd_data |=> IO_RDATA_VALID && IO_RDATA[7:6] == 2'b00;
    endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("data byte malformed");

    property p_rd_incr;
        rd_data && s.comp == ppps_pkg::COMP_BLUE && s.status == ppps_pkg::STATUS_READ |=>
            s.rd_idx == $past(s.rd_idx) + 8'h01 && s.comp == ppps_pkg::COMP_RED;
    endproperty
    a_rd_incr: assert property (p_rd_incr) else $error("read index not advanced");

    property p_wr_store;
        wr_data && s.comp == ppps_pkg::COMP_BLUE && s.status == ppps_pkg::STATUS_WRITE |=>
            s.lut[$past(s.wr_idx)] == {$past(s.red), $past(s.green), $past(IO_WDATA[5:0])} &&
            s.wr_idx == $past(s.wr_idx) + 8'h01;
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("entry not stored");

    property p_status_rd;
        IO_RD && IO_ADDR == ppps_pkg::ADDR_RD_INDEX && !IO_WR |=>
            IO_RDATA == {6'h00, $past(s.status)} && s.comp == $past(s.comp);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read disturbed");

    c_read_triple: cover property (rd_data && s.comp == ppps_pkg::COMP_BLUE);
    c_write_triple: cover property (wr_data && s.comp == ppps_pkg::COMP_BLUE);
    c_byte_mode: cover property (byte_mode && s.phase);
    c_nine_zero: cover property (NINE_DOT && !graphics && s.shift[3:0] == ppps_pkg::NINE_DOT_ZERO_CODE);
    c_toggle_reset: cover property (IO_RD && IO_ADDR == ppps_pkg::ADDR_STAT_MONO);

    // Eight-dot text and non-byte graphics shift by the plain code
    property p_eight;
        !ENHANCED_MAP && !byte_mode && (graphics || !NINE_DOT) |=>
            PAN_SHIFT == {1'b0, $past(s.shift[2:0])};
    endproperty
    a_eight: assert property (p_eight) else $error("eight-dot shift wrong");

    // Top colour bits come from high-colour whenever nibbles are not paired
    property p_top_bits;
        !byte_mode |=> s.color[7:6] == $past(s.hicolor[3:2]);
    endproperty
    a_top_bits: assert property (p_top_bits) else $error("top colour bits wrong");

    // Bypass replaces the palette bits 5-4 with high-colour bits 1-0
    property p_bypass;
        !byte_mode && bypass |=> s.color[5:4] == $past(s.hicolor[1:0]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bits wrong");

    // A write-index load starts a fresh triple in write mode
    property p_wr_start;
        IO_WR && !IO_RD && IO_ADDR == ppps_pkg::ADDR_WR_INDEX |=>
            s.status == ppps_pkg::STATUS_WRITE && s.comp == ppps_pkg::COMP_RED && s.wr_idx == $past(IO_WDATA);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write sequence not started");

    // First byte of a triple keeps only its low six bits
    property p_wr_red;
        wr_data && !IO_RD && s.comp == ppps_pkg::COMP_RED |=>
            s.red == $past(IO_WDATA[5:0]) && s.comp == ppps_pkg::COMP_GREEN;
    endproperty
    a_wr_red: assert property (p_wr_red) else $error("red byte not captured");

    // Each attribute write flips the toggle; a status read in the same cycle would clear it
    property p_toggle;
        IO_WR && IO_ADDR == ppps_pkg::ADDR_ATTR_WR && !IO_RD |=> s.attr_toggle != $past(s.attr_toggle);
    endproperty
    a_toggle: assert property (p_toggle) else $error("attribute toggle stuck");
endmodule : ppps_top
`default_nettype wire

//--- common/ppps_pkg.sv
// Constants and types for the palette port and pixel shift block.
// Assumes a byte-wide host I/O bus and one synchronous 20 MHz clock.
`default_nettype none
package ppps_pkg;
    // Host I/O addresses
    localparam logic [15:0] ADDR_ATTR_WR = 16'h03c0;
    localparam logic [15:0] ADDR_ATTR_RD = 16'h03c1;
    localparam logic [15:0] ADDR_MASK = 16'h03c6;
    localparam logic [15:0] ADDR_RD_INDEX = 16'h03c7;
    localparam logic [15:0] ADDR_WR_INDEX = 16'h03c8;
    localparam logic [15:0] ADDR_DATA = 16'h03c9;
    localparam logic [15:0] ADDR_STAT_MONO = 16'h03ba;
    localparam logic [15:0] ADDR_STAT_COLOR = 16'h03da;
    // Attribute indices
    localparam logic [4:0] IDX_MODE = 5'h10;
    localparam logic [4:0] IDX_PLANE = 5'h12;
    localparam logic [4:0] IDX_SHIFT = 5'h13;
    localparam logic [4:0] IDX_HICOLOR = 5'h14;
    // Field positions and writable masks
    localparam int MODE_GRAPHICS_BIT = 0;
    localparam int MODE_BYTE_PIX_BIT = 6;
    localparam int MODE_BYPASS_BIT = 7;
    localparam int PLANE_VTS_LSB = 4;
    localparam logic [7:0] MODE_WR_MASK = 8'hef;
    localparam logic [7:0] PLANE_WR_MASK = 8'h3f;
    localparam logic [7:0] LOW_NIBBLE_MASK = 8'h0f;
    localparam logic [3:0] NINE_DOT_ZERO_CODE = 4'h8;
    // Cycle status codes
    localparam logic [1:0] STATUS_WRITE = 2'h0;
    localparam logic [1:0] STATUS_READ = 2'h3;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'hff;

    // Position within a colour triple
    typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} ppps_comp_t;

    // One host I/O access
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } ppps_io_req_t;

    // Whole block state
    typedef struct packed {
        logic attr_toggle;
        logic [5:0] attr_index;
        logic [7:0] mode;
        logic [7:0] plane;
        logic [7:0] shift;
        logic [7:0] hicolor;
        logic [7:0] mask;
        logic [7:0] rd_idx;
        logic [7:0] wr_idx;
        logic [1:0] status;
        ppps_comp_t comp;
        logic [5:0] red;
        logic [5:0] green;
        logic [17:0] hold;
        logic [255:0][17:0] lut;
        logic phase;
        logic [3:0] nib_hi;
        logic [7:0] color;
        logic [7:0] pix_addr;
        logic [17:0] rgb;
        logic [3:0] pan;
        logic [7:0] rdata;
        logic rvalid;
    } ppps_state_t;
endpackage : ppps_pkg
`default_nettype wire

//--- verification/ppps_host.sv
// Host processor model issuing byte-wide I/O cycles to the palette block.
// Assumes the block takes a strobe on the rising edge of clk.
`default_nettype none
module ppps_host (
    input wire logic clk,
    output logic [15:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rdata_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One write strobe; afterwards lines show inverted values, never a stale match
    // Callers finish every data triple before switching direction
    // No display timing here: all data-port traffic is taken as made during blanking
    task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : wr_io

    // One read strobe; data taken while the valid pulse stands
    task automatic rd_io(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1;
        io_rd = 1'b0;
        io_addr = ~a;
        // Missing valid turns the value unknown so every compare fails
        d = (io_rdata_valid === 1'b1) ? io_rdata : 8'hxx;
    endtask : rd_io
endmodule : ppps_host
`default_nettype wire

//--- verification/tb_palette_port_and_pixel_shift.sv
// Self-checking bench for the palette port and pixel shift block.
// Assumes ppps_host as host model and a 20 MHz reference clock.
`default_nettype none
module tb_palette_port_and_pixel_shift;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk;
    logic rst;
    logic [15:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_rdata_valid;
    logic enhanced_map = 1'b0;
    logic nine_dot = 1'b0;
    logic [5:0] pal_color = 6'h00;
    logic [3:0] pix_nibble = 4'h9;
    logic [7:0] pix_addr;
    logic [17:0] lut_rgb;
    logic [3:0] pan_shift;
    logic [1:0] video_status;
    int fail_count = 0;
    int total_checks = 0;
    // Expected stream of two triples, and tables for status and pan loops
    logic [7:0] rd_exp [6] = '{8'h01, 8'h02, 8'h03, 8'h3f, 8'h3e, 8'h3d};
    logic [7:0] mode_tab [5] = '{8'h00, 8'h00, 8'h01, 8'h41, 8'h01};
    int hi_bit [4] = '{2, 5, 3, 7};
    int lo_bit [4] = '{0, 4, 1, 6};
    logic [7:0] cb = 8'hde;

    ppps_host host (.clk(ref_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
    ppps_top dut (.REF_CLK(ref_clk), .RST(rst), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
        .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_RDATA_VALID(io_rdata_valid),
        .ENHANCED_MAP(enhanced_map), .NINE_DOT(nine_dot), .PAL_COLOR(pal_color), .PIX_NIBBLE(pix_nibble),
        .PIX_ADDR(pix_addr), .LUT_RGB(lut_rgb), .PAN_SHIFT(pan_shift), .VIDEO_STATUS(video_status));

    ////////////////////////////////////////////////////////////////////////////
    // 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers: compare, read-compare, attribute pair, idle cycles
    task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd_io(a, d);
        chk(name, 18'(exp), 18'(d));
    endtask : rd_chk
    task automatic attr(input logic [4:0] idx, input logic [7:0] val);
        host.wr_io(ppps_pkg::ADDR_ATTR_WR, 8'(idx));
        host.wr_io(ppps_pkg::ADDR_ATTR_WR, val);
    endtask : attr
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // Mode 0 nine-dot text, 1 eight-dot text, 2 graphics, 3 byte pixel, 4 enhanced
    function automatic logic [3:0] pan_exp(input int m, input int c);
        if (m == 4) return 4'h0;
        if (m == 3) return 4'(c / 2);
        if (m == 0) return (c == 8) ? 4'h0 : 4'(c + 1);
        return 4'(c);
    endfunction : pan_exp

    ////////////////////////////////////////////////////////////////////////////
    // Verdict; the only exit of the run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(20000 * 50);
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        // Reset values and a refused address
        rd_chk("mask reset", ppps_pkg::ADDR_MASK, 8'hff);
        rd_chk("status reset", ppps_pkg::ADDR_RD_INDEX, 8'h00);
        rd_chk("unmapped", 16'h03c5, 8'h00);
        // Two triples from fe, upper bits set, index reads mid-triple
        host.wr_io(ppps_pkg::ADDR_WR_INDEX, 8'hfe);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'hc1);
        rd_chk("status mid write", ppps_pkg::ADDR_RD_INDEX, 8'h00);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h82);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h43);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h3f);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'hfe);
        rd_chk("write index mid", ppps_pkg::ADDR_WR_INDEX, 8'hff);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h7d);
        rd_chk("write index wrap", ppps_pkg::ADDR_WR_INDEX, 8'h00);
        // Stream back both entries across the auto-increment
        host.wr_io(ppps_pkg::ADDR_RD_INDEX, 8'hfe);
        rd_chk("status read", ppps_pkg::ADDR_RD_INDEX, 8'h03);
        for (int i = 0; i < 6; i++) begin
            if (i == 2) begin
                rd_chk("write index mid read", ppps_pkg::ADDR_WR_INDEX, 8'h00);
            end
            rd_chk("data", ppps_pkg::ADDR_DATA, rd_exp[i]);
        end
        // Data port follows whichever index was loaded last
        host.wr_io(ppps_pkg::ADDR_WR_INDEX, 8'h10);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h0a);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h0b);
        host.wr_io(ppps_pkg::ADDR_DATA, 8'h0c);
        rd_chk("status write", ppps_pkg::ADDR_RD_INDEX, 8'h00);
        host.wr_io(ppps_pkg::ADDR_RD_INDEX, 8'h10);
        rd_chk("data after switch", ppps_pkg::ADDR_DATA, 8'h0a);
        // Pixel path: high-colour on top, mask, table lookup
        rd_chk("status port colour", ppps_pkg::ADDR_STAT_COLOR, 8'h00);
        attr(ppps_pkg::IDX_HICOLOR, 8'h0c);
        pal_color = 6'h3e;
        tick(4);
        chk("pixel address", 18'(8'hfe), 18'(pix_addr));
        chk("lookup", 18'h01083, lut_rgb);
        host.wr_io(ppps_pkg::ADDR_MASK, 8'h7f);
        rd_chk("mask", ppps_pkg::ADDR_MASK, 8'h7f);
        tick(4);
        chk("masked address", 18'(8'h7e), 18'(pix_addr));
        chk("masked lookup", 18'h00000, lut_rgb);
        host.wr_io(ppps_pkg::ADDR_MASK, 8'hff);
        attr(ppps_pkg::IDX_MODE, 8'h80);
        attr(ppps_pkg::IDX_HICOLOR, 8'h0d);
        tick(4);
        chk("bypass address", 18'(cb), 18'(pix_addr));
        // Every test select code against the colour byte de
        for (int s = 0; s < 4; s++) begin
            attr(ppps_pkg::IDX_PLANE, 8'(s << 4));
            tick(2);
            chk("video status", 18'({cb[hi_bit[s]], cb[lo_bit[s]]}), 18'(video_status));
        end
        // Byte pixel mode joins two nibbles
        attr(ppps_pkg::IDX_MODE, 8'h41);
        tick(4);
        chk("byte pixel", 18'(8'h99), 18'(pix_addr));
        // Reserved shift bits read as zero
        attr(ppps_pkg::IDX_SHIFT, 8'hf6);
        rd_chk("shift readback", ppps_pkg::ADDR_ATTR_RD, 8'h06);
        rd_chk("attribute index", ppps_pkg::ADDR_ATTR_WR, 8'h13);
        // Half a pair, then a status read puts the toggle back on the index
        host.wr_io(ppps_pkg::ADDR_ATTR_WR, 8'(ppps_pkg::IDX_MODE));
        rd_chk("status port mono", ppps_pkg::ADDR_STAT_MONO, 8'h00);
        // Pan table over every mode and legal code
        for (int m = 0; m < 5; m++) begin
            attr(ppps_pkg::IDX_MODE, mode_tab[m]);
            nine_dot = (m == 0);
            enhanced_map = (m == 4);
            for (int c = 0; c < 9; c++) begin
                if ((c == 8 && m != 0) || (m == 3 && c % 2 == 1)) continue;
                attr(ppps_pkg::IDX_SHIFT, 8'(c));
                tick(3);
                chk("pan", 18'(pan_exp(m, c)), 18'(pan_shift));
            end
        end
        // Mid-run reset brings back the mask and status defaults
        host.wr_io(ppps_pkg::ADDR_MASK, 8'h3c);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        rd_chk("mask after reset", ppps_pkg::ADDR_MASK, 8'hff);
        rd_chk("status after reset", ppps_pkg::ADDR_RD_INDEX, 8'h00);
        stop_test();
    end
endmodule : tb_palette_port_and_pixel_shift
`default_nettype wire
